// ### include/group1_alias_map.svh
// offsets, field positions, reset values and sizes of the group 1 alias block
//==============================================================================
`ifndef GROUP1_ALIAS_MAP_SVH
`define GROUP1_ALIAS_MAP_SVH
//==============================================================================
// build options
`define SEC_EXT 1'b1
`define MULTI_CPU 1'b1
//==============================================================================
// register offsets
`define OFF_CONTROL 8'h00
`define OFF_ACK 8'h04
`define OFF_EOI 8'h08
`define OFF_HIGHEST 8'h0c
`define OFF_LAST_ACK 8'h10
`define OFF_APR_PAGE 4'h2
`define OFF_NSAPR_PAGE 4'h3
//==============================================================================
// fields and values
`define CTL_ACK_CTL 0
`define CTL_EOI_MODE_S 1
`define CTL_EOI_MODE_NS 2
`define CTL_RESET 3'h0
`define SPURIOUS_ID 10'h3ff
`define SGI_LIMIT 10'h010
`define AP_REGS 4
`define AP_NS_BASE 2'h2
`define AP_NS_REGS 2'h2
`endif

// ### include/group1_alias_pkg.sv
// types shared by the group 1 alias block
package group1_alias_pkg;
  typedef struct packed {
    logic valid;
    logic group1;
    logic active;
    logic [7:0] prio;
    logic [2:0] srcCpu;
    logic [9:0] id;
  } pending_t;
  typedef struct packed {
    logic [2:0] cpu;
    logic [9:0] id;
  } intref_t;
endpackage

// ### src/group1_alias_cpu_if.sv
// group 1 aliased acknowledge, end-of-interrupt, highest pending and active priorities
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "group1_alias_map.svh"
module group1_alias_cpu_if (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic regSecure,
  output logic [31:0] regRdata,
  // highest pending from prioritisation
  input group1_alias_pkg::pending_t pend,
  // acknowledge to distributor
  output logic ackStrobe,
  output group1_alias_pkg::intref_t ackRef,
  // end of interrupt to distributor
  output logic dropStrobe,
  output logic deactStrobe,
  output group1_alias_pkg::intref_t eoiRef
);

  //==========================================================================
  // access decode
  logic secOk;
  logic nsView;
  logic ackRead;
  logic eoiWrite;
  logic ctlWrite;
  logic aprWrite;
  logic nsaprWrite;
  logic [1:0] wordIdx;
  logic [1:0] nsWordIdx;

  assign secOk = !`SEC_EXT || regSecure;
  assign nsView = `SEC_EXT && !regSecure;
  assign ackRead = regRead && (regAddr == `OFF_ACK) && secOk;
  assign eoiWrite = regWrite && (regAddr == `OFF_EOI) && secOk;
  assign ctlWrite = regWrite && (regAddr == `OFF_CONTROL);
  assign aprWrite = regWrite && (regAddr[7:4] == `OFF_APR_PAGE);
  assign nsaprWrite = regWrite && (regAddr[7:4] == `OFF_NSAPR_PAGE) && secOk;
  assign wordIdx = regAddr[3:2];
  assign nsWordIdx = 2'(wordIdx + `AP_NS_BASE);

  //==========================================================================
  // control bits
  logic [2:0] ctl_q;
  logic eoiMode;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= `CTL_RESET;
    end else if (ctlWrite && secOk) begin
      ctl_q <= regWdata[2:0];
    end else if (ctlWrite) begin
      // non-secure may only touch its own mode bit
      ctl_q[`CTL_EOI_MODE_NS] <= regWdata[`CTL_EOI_MODE_NS];
    end
  end

  assign eoiMode = `SEC_EXT ? ctl_q[`CTL_EOI_MODE_S] : ctl_q[`CTL_EOI_MODE_NS];

  //==========================================================================
  // highest pending group 1 interrupt
  logic hpGrp1;
  group1_alias_pkg::intref_t hpRef;

  assign hpGrp1 = pend.valid && pend.group1 && !pend.active;

  always_comb begin
    hpRef.id = `SPURIOUS_ID;
    hpRef.cpu = 3'h0;
    if (hpGrp1) begin
      hpRef.id = pend.id;
      if (`MULTI_CPU && (pend.id < `SGI_LIMIT)) begin
        hpRef.cpu = pend.srcCpu;
      end
    end
  end

  //==========================================================================
  // acknowledge
  logic ackTake;
  group1_alias_pkg::intref_t lastAck_q;

  assign ackTake = ackRead && hpGrp1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ackStrobe <= 1'b0;
      ackRef <= '0;
    end else begin
      ackStrobe <= ackTake;
      if (ackTake) begin
        ackRef <= hpRef;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lastAck_q <= '0;
    end else if (ackTake) begin
      lastAck_q <= hpRef;
    end
  end

  //==========================================================================
  // end of interrupt
  logic eoiTake;
  group1_alias_pkg::intref_t eoiIn;

  assign eoiIn.cpu = regWdata[12:10];
  assign eoiIn.id = regWdata[9:0];
  assign eoiTake = eoiWrite && (eoiIn.id != `SPURIOUS_ID);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dropStrobe <= 1'b0;
      deactStrobe <= 1'b0;
      eoiRef <= '0;
    end else begin
      dropStrobe <= eoiTake;
      deactStrobe <= eoiTake && !eoiMode;
      if (eoiTake) begin
        eoiRef <= eoiIn;
      end
    end
  end

  //==========================================================================
  // active priorities storage
  logic [31:0] grp0Apr_q [`AP_REGS];
  logic [31:0] grp1Apr_q [`AP_REGS];
  logic [127:0] grp1Flat;
  logic [6:0] ackLevel;
  logic dropFound;
  logic [6:0] dropLevel;

  assign ackLevel = pend.prio[7:1];

  // highest priority active level is the lowest set bit
  function automatic logic [7:0] lowestSet(input logic [127:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 127; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 7'(i)};
      end
    end
    return r;
  endfunction

  assign {dropFound, dropLevel} = lowestSet(grp1Flat);

  genvar n;
  generate
    for (n = 0; n < `AP_REGS; n++) begin : g_word
      logic g0Wr;
      logic g1Wr;
      logic setHit;
      logic clrHit;

      assign g0Wr = aprWrite && !nsView && (wordIdx == 2'(n));
      assign g1Wr = (nsaprWrite && (wordIdx == 2'(n))) ||
        (aprWrite && nsView && (wordIdx < `AP_NS_REGS) && (nsWordIdx == 2'(n)));
      assign setHit = ackTake && (ackLevel[6:5] == 2'(n));
      assign clrHit = eoiTake && dropFound && (dropLevel[6:5] == 2'(n));
      assign grp1Flat[n*32 +: 32] = grp1Apr_q[n];

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          grp0Apr_q[n] <= 32'h0;
        end else if (g0Wr) begin
          grp0Apr_q[n] <= regWdata;
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          grp1Apr_q[n] <= 32'h0;
        end else if (g1Wr) begin
          grp1Apr_q[n] <= regWdata;
        end else if (setHit) begin
          grp1Apr_q[n][ackLevel[4:0]] <= 1'b1;
        end else if (clrHit) begin
          grp1Apr_q[n][dropLevel[4:0]] <= 1'b0;
        end
      end
    end
  endgenerate

  //==========================================================================
  // read data
  logic [31:0] rdNext;

  always_comb begin
    rdNext = 32'h0;
    case (regAddr[7:4])
      4'h0: begin
        case (regAddr)
          `OFF_CONTROL: begin
            if (secOk) begin
              rdNext = {29'h0, ctl_q};
            end else begin
              rdNext = {29'h0, ctl_q[`CTL_EOI_MODE_NS], 2'h0};
            end
          end
          `OFF_ACK: begin
            if (secOk) begin
              rdNext = {19'h0, hpRef};
            end
          end
          `OFF_HIGHEST: begin
            if (secOk) begin
              rdNext = {19'h0, hpRef};
            end
          end
          default: begin
            rdNext = 32'h0;
          end
        endcase
      end
      4'h1: begin
        if (regAddr == `OFF_LAST_ACK) begin
          rdNext = {19'h0, lastAck_q};
        end
      end
      `OFF_APR_PAGE: begin
        if (!nsView) begin
          rdNext = grp0Apr_q[wordIdx];
        end else if (wordIdx < `AP_NS_REGS) begin
          rdNext = grp1Apr_q[nsWordIdx];
        end
      end
      `OFF_NSAPR_PAGE: begin
        if (secOk) begin
          rdNext = grp1Apr_q[wordIdx];
        end
      end
      default: begin
        rdNext = 32'h0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 32'h0;
    end else if (regRead) begin
      regRdata <= rdNext;
    end else begin
      regRdata <= 32'h0;
    end
  end

endmodule // group1_alias_cpu_if

// ### verification/group1_alias_checker.sv
// port assertions of the group 1 alias block
`timescale 1ns/1ps
`include "group1_alias_map.svh"
module group1_alias_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic regSecure,
  input wire logic [31:0] regRdata,
  // interrupt side
  input wire group1_alias_pkg::pending_t pend,
  input wire logic ackStrobe,
  input wire group1_alias_pkg::intref_t ackRef,
  input wire logic dropStrobe,
  input wire logic deactStrobe,
  input wire group1_alias_pkg::intref_t eoiRef
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic live, sAck, sHi, sEoi;
  logic [2:0] cpuX;
  assign live = pend.valid && pend.group1 && !pend.active;
  assign sAck = regRead && regSecure && regAddr == `OFF_ACK;
  assign sHi = regRead && regSecure && regAddr == `OFF_HIGHEST;
  assign sEoi = regWrite && regSecure && regAddr == `OFF_EOI && regWdata[9:0] != `SPURIOUS_ID;
  assign cpuX = (pend.id < `SGI_LIMIT) ? pend.srcCpu : 3'h0;
  a_ack_value:
  assert property (sAck && live |=> ackStrobe && regRdata == {19'h0, $past(cpuX), $past(pend.id)})
    else $error("ack value");
  a_ack_ref:
  assert property (sAck && live |=> ackRef == {$past(cpuX), $past(pend.id)}) else $error("ack ref");
  a_ack_cause:
  assert property (ackStrobe |-> $past(sAck && live)) else $error("stray ack");
  a_ack_none:
  assert property (sAck && !live |=> !ackStrobe && regRdata == {22'h0, `SPURIOUS_ID})
    else $error("empty ack");
  a_high_value:
  assert property (sHi |=> regRdata == ($past(live) ? {19'h0, $past(cpuX), $past(pend.id)}
    : {22'h0, `SPURIOUS_ID})) else $error("highest value");
  a_alias_secure_only:
  assert property (regRead && !regSecure && regAddr inside {`OFF_ACK, `OFF_HIGHEST}
    |=> regRdata == 32'h0 && !ackStrobe) else $error("alias open");
  a_eoi_drop:
  assert property (sEoi |=> dropStrobe && eoiRef == $past(regWdata[12:0])) else $error("no drop");
  a_drop_cause:
  assert property (dropStrobe || deactStrobe |-> $past(sEoi)) else $error("stray drop");
  c_ack: cover property (sAck && live);
  c_eoi: cover property (sEoi);
  c_high_none: cover property (sHi && !live);
endmodule // group1_alias_checker
bind group1_alias_cpu_if group1_alias_checker i_chk (.clk(clk), .rst_n(rst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regSecure(regSecure), .regRdata(regRdata), .pend(pend), .ackStrobe(ackStrobe),
  .ackRef(ackRef), .dropStrobe(dropStrobe), .deactStrobe(deactStrobe), .eoiRef(eoiRef));

// ### verification/group1_alias_prio_model.sv
// prioritiser stand-in: one interrupt through pending, active and deactivated
`timescale 1ns/1ps
module group1_alias_prio_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // load from bench
  input wire logic load,
  input wire group1_alias_pkg::pending_t loadVal,
  // from the interface
  input wire logic ackStrobe,
  input wire logic deactStrobe,
  // highest pending
  output group1_alias_pkg::pending_t pend
);
  // acked stays pending too, as a level source would
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= '0;
    end else if (load) begin
      pend <= loadVal;
    end else if (deactStrobe) begin
      pend <= '0;
    end else if (ackStrobe) begin
      pend.active <= 1'b1;
    end
  end
endmodule // group1_alias_prio_model

// ### verification/test_group1_alias_ack_eoi_active_prio.sv
// self-checking bench of the group 1 alias block
`timescale 1ns/1ps
`include "group1_alias_map.svh"
module test_group1_alias_ack_eoi_active_prio;
  logic clk, rst_n, regWrite, regRead, regSecure, load, ackStrobe, dropStrobe, deactStrobe;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic [1:0] ends;
  group1_alias_pkg::pending_t pend, loadVal;
  group1_alias_pkg::intref_t ackRef, eoiRef;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  group1_alias_cpu_if i_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regSecure(regSecure), .regRdata(regRdata),
    .pend(pend), .ackStrobe(ackStrobe), .ackRef(ackRef), .dropStrobe(dropStrobe),
    .deactStrobe(deactStrobe), .eoiRef(eoiRef));
  group1_alias_prio_model i_prio (.clk(clk), .rst_n(rst_n), .load(load), .loadVal(loadVal),
    .ackStrobe(ackStrobe), .deactStrobe(deactStrobe), .pend(pend));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic s);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regSecure <= s;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    #1 ends = {dropStrobe, deactStrobe};
  endtask
  task automatic rdc(input logic [7:0] a, input logic s, input logic [31:0] exp);
    @(posedge clk);
    regAddr <= a;
    regSecure <= s;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(regRdata, exp);
  endtask
  task automatic ld(input logic g1, input logic [7:0] p, input logic [2:0] c, input logic [9:0] i);
    @(posedge clk);
    loadVal <= {1'b1, g1, 1'b0, p, c, i};
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
  endtask
  initial begin
    rst_n = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regSecure = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    load = 1'b0;
    loadVal = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`OFF_CONTROL, 1'b1, 32'h0);
    ld(1'b1, 8'h40, 3'h3, 10'h005);
    rdc(`OFF_HIGHEST, 1'b1, 32'h0000_0c05);
    rdc(`OFF_HIGHEST, 1'b0, 32'h0);
    rdc(`OFF_ACK, 1'b0, 32'h0);
    rdc(`OFF_ACK, 1'b1, 32'h0000_0c05);
    rdc(`OFF_LAST_ACK, 1'b1, 32'h0000_0c05);
    rdc(`OFF_HIGHEST, 1'b1, 32'h0000_03ff);
    rdc(`OFF_ACK, 1'b1, 32'h0000_03ff);
    rdc(8'h34, 1'b1, 32'h0000_0001);
    rdc(8'h20, 1'b1, 32'h0);
    wr(`OFF_EOI, 32'h0000_0c05, 1'b1);
    chk({30'h0, ends}, 32'h3);
    rdc(8'h34, 1'b1, 32'h0);
    wr(`OFF_CONTROL, 32'h0000_0002, 1'b1);
    ld(1'b1, 8'hc2, 3'h5, 10'h028);
    rdc(`OFF_HIGHEST, 1'b1, 32'h0000_0028);
    rdc(`OFF_ACK, 1'b1, 32'h0000_0028);
    rdc(8'h24, 1'b0, 32'h0000_0002);
    rdc(8'h28, 1'b0, 32'h0);
    wr(`OFF_EOI, 32'h0000_0028, 1'b0);
    chk({30'h0, ends}, 32'h0);
    wr(`OFF_EOI, 32'h0000_0028, 1'b1);
    chk({30'h0, ends}, 32'h2);
    rdc(8'h3c, 1'b1, 32'h0);
    ld(1'b0, 8'h10, 3'h1, 10'h002);
    rdc(`OFF_HIGHEST, 1'b1, 32'h0000_03ff);
    wr(8'h20, 32'h0000_00a5, 1'b1);
    wr(8'h20, 32'h0000_0001, 1'b0);
    rdc(8'h20, 1'b1, 32'h0000_00a5);
    rdc(8'h38, 1'b1, 32'h0000_0001);
    rdc(8'h80, 1'b1, 32'h0);
    conclude();
  end
endmodule // test_group1_alias_ack_eoi_active_prio
